// [core/tap_decode.sv]
// scan-port controller with instruction decode and data register select
`default_nettype none
// Function
// [RULE1] pass-through instruction puts the one-bit cell between serial in and out
// [RULE2] code 111 selects the pass-through cell, memory untouched
// [RULE3] external-test instruction puts the boundary chain on the serial path
// [RULE4] code 000 captures the pin ring, selects chain, floats memory outputs
// [RULE5] external-test drives preloaded cells; conflicts with float, float kept
// [RULE6] code 001 loads the fixed identity word and selects it
// [RULE7] code 010 captures pins, selects chain, floats all outputs
// [RULE8] code 100 captures pins, selects chain, memory keeps running
// [RULE9] the controller must never load codes 011, 101 or 110; the code loads them on update and treats them as pass-through
// [RULE10] identity word 32 bits: version 31:29, device 28:12, vendor 11:1
// [RULE11] identity bit 0 always reads one
// [RULE12] boundary chain is 69 cells long
// [RULE13] instruction register three bits, captures 01 in low bits
// [RULE14] five rising edges with mode high reset port, load identity
// [RULE15] inputs sampled on rising edge, serial out changes on falling
// [RULE16] new instruction takes effect only in update-instruction state
module tap_decode
  import tap_decode_pkg::*;
#(
  parameter logic [2:0]  VER_CODE  = ID_VER_DEF,  // arbitrary value
  parameter logic [16:0] DEV_CODE  = ID_DEV_DEF,  // arbitrary value
  parameter logic [10:0] VEND_CODE = ID_VEND_DEF, // arbitrary value
  parameter int unsigned CHAIN_LEN = BSR_LEN
) (
  // core clock side
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  // test link, runs on its own clock
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdo_oe,
  // pin ring as seen by the chain, in core domain
  input  wire logic [CHAIN_LEN-1:0] ring_in,
  // core-domain results
  output logic                      outputs_hiz_q,
  output logic                      drive_preload_q,
  output logic [CHAIN_LEN-1:0]      preload_q,
  output logic [IR_W-1:0]           active_instr_q,
  output logic                      preload_valid_q
);
  // ------------------------------------------------------------
  // test-clock side state
  // ------------------------------------------------------------
  tap_state_t             st_q;
  tap_state_t             st_d;
  logic [IR_W-1:0]        ir_shift_q;
  logic [IR_W-1:0]        ir_q;
  logic                   pass_q;
  logic [ID_W-1:0]        id_q;
  logic [CHAIN_LEN-1:0]   bsr_q;
  logic [CHAIN_LEN-1:0]   upd_q;
  logic                   upd_tgl_q;
  logic                   tdo_bit;
  logic                   tdo_en;
  logic [2:0]             hi_cnt_q;
  logic [CHAIN_LEN-1:0]   ring_t1_q;
  logic [CHAIN_LEN-1:0]   ring_t2_q;
  logic [ID_W-1:0]        id_word;

  // chain selection for the current instruction
  function automatic logic sel_chain(input logic [IR_W-1:0] ins);
    return ins == IR_EXT_TEST || ins == IR_SAMPLE_HIZ ||
           ins == IR_SAMPLE_PRE;
  endfunction : sel_chain

  // [RULE10] [RULE11] hardwired identity fields, presence bit last
  assign id_word = {VER_CODE, DEV_CODE, VEND_CODE, ID_PRESENT};

  // state transitions, tms sampled on rising edge
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_RESET:    st_d = tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     st_d = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   st_d = tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   st_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: st_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: st_d = tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: st_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: st_d = tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   st_d = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   st_d = tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   st_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: st_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: st_d = tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: st_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: st_d = tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   st_d = tms ? ST_SEL_DR   : ST_IDLE;
    endcase
  end

  // [RULE14] the state graph alone reaches reset after five high edges;
  // the counter forces it too, so a glitch cannot hide the sequence
  always_ff @(posedge tck) begin
    if (srst) begin
      hi_cnt_q <= '0;
    end else if (!tms) begin
      hi_cnt_q <= '0;
    end else if (hi_cnt_q != 3'(RESET_HIGH_EDGES)) begin
      hi_cnt_q <= hi_cnt_q + 3'h1;
    end
  end

  // controller state register
  always_ff @(posedge tck) begin
    if (srst) begin
      st_q <= ST_RESET;
    end else if (tms && hi_cnt_q == 3'(RESET_HIGH_EDGES - 1)) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // [RULE13] instruction shift stage, captures 01 in low bits
  always_ff @(posedge tck) begin
    if (srst) begin
      ir_shift_q <= IR_ID_READ;
    end else if (st_q == ST_CAP_IR) begin
      ir_shift_q <= {ir_shift_q[IR_W-1], IR_CAPTURE_LSB};
    end else if (st_q == ST_SHIFT_IR) begin
      ir_shift_q <= {tdi, ir_shift_q[IR_W-1:1]};
    end
  end

  // [RULE16] active instruction changes only on update; reset loads id
  always_ff @(posedge tck) begin
    if (srst || st_q == ST_RESET) begin
      ir_q <= IR_ID_READ;
    end else if (st_q == ST_UPD_IR) begin
      ir_q <= ir_shift_q;
    end
  end

  // [RULE1] single pass-through cell, cleared on capture
  always_ff @(posedge tck) begin
    if (srst) begin
      pass_q <= 1'b0;
    end else if (st_q == ST_CAP_DR) begin
      pass_q <= 1'b0;
    end else if (st_q == ST_SHIFT_DR) begin
      pass_q <= tdi;
    end
  end

  // [RULE6] identity word loaded on capture, shifted lsb first
  always_ff @(posedge tck) begin
    if (srst) begin
      id_q <= '0;
    end else if (st_q == ST_CAP_DR && ir_q == IR_ID_READ) begin
      id_q <= id_word;
    end else if (st_q == ST_SHIFT_DR && ir_q == IR_ID_READ) begin
      id_q <= {tdi, id_q[ID_W-1:1]};
    end
  end

  // ring enters the test domain through two flops per bit
  always_ff @(posedge tck) begin
    ring_t1_q <= ring_in;
    ring_t2_q <= ring_t1_q;
  end

  // [RULE12] boundary chain; [RULE4] [RULE7] [RULE8] capture the ring
  always_ff @(posedge tck) begin
    if (srst) begin
      bsr_q <= '0;
    end else if (st_q == ST_CAP_DR && sel_chain(ir_q)) begin
      bsr_q <= ring_t2_q;
    end else if (st_q == ST_SHIFT_DR && sel_chain(ir_q)) begin
      // [RULE3] chain between serial in and out
      bsr_q <= {tdi, bsr_q[CHAIN_LEN-1:1]};
    end
  end

  // update stage holds preload values, handed over by toggle
  always_ff @(posedge tck) begin
    if (srst) begin
      upd_q     <= '0;
      upd_tgl_q <= 1'b0;
    end else if (st_q == ST_UPD_DR && sel_chain(ir_q)) begin
      upd_q     <= bsr_q;
      upd_tgl_q <= ~upd_tgl_q;
    end
  end

  // [RULE1] [RULE2] serial output mux; reserved codes fall to pass-through
  always_comb begin
    tdo_en = (st_q == ST_SHIFT_DR) || (st_q == ST_SHIFT_IR);
    if (st_q == ST_SHIFT_IR) begin
      tdo_bit = ir_shift_q[0];
    end else if (sel_chain(ir_q)) begin
      tdo_bit = bsr_q[0];
    end else if (ir_q == IR_ID_READ) begin
      tdo_bit = id_q[0];
    end else begin
      tdo_bit = pass_q;
    end
  end

  // [RULE15] serial output changes only on the falling edge
  always_ff @(negedge tck) begin
    if (srst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= tdo_bit;
      tdo_oe <= tdo_en;
    end
  end

  // ------------------------------------------------------------
  // core-clock side
  // ------------------------------------------------------------
  logic [IR_W-1:0]      ir_c1_q;
  logic [IR_W-1:0]      ir_c2_q;
  logic                 tgl_c1_q;
  logic                 tgl_c2_q;
  logic                 tgl_c3_q;
  logic                 f_in_ready;
  logic                 f_out_valid;
  logic [CHAIN_LEN-1:0] f_out_data;

  // instruction crosses as a level; it only moves at update or in test reset and is
  // stable for many core cycles, so a short skew window is harmless
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ir_c1_q <= IR_ID_READ;
      ir_c2_q <= IR_ID_READ;
    end else begin
      ir_c1_q <= ir_q;
      ir_c2_q <= ir_c1_q;
    end
  end

  // update toggle synchroniser, edge found on second and third stages
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tgl_c1_q <= 1'b0;
      tgl_c2_q <= 1'b0;
      tgl_c3_q <= 1'b0;
    end else begin
      tgl_c1_q <= upd_tgl_q;
      tgl_c2_q <= tgl_c1_q;
      tgl_c3_q <= tgl_c2_q;
    end
  end

  // preload words staged; upd_q is stable long after its toggle
  word_fifo #(
    .WIDTH (CHAIN_LEN),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst       (srst),
    .in_valid  (tgl_c2_q ^ tgl_c3_q),
    .in_ready  (f_in_ready),
    .in_data   (upd_q),
    .out_valid (f_out_valid),
    .out_ready (1'b1),
    .out_data  (f_out_data)
  );

  // [RULE4] [RULE7] [RULE5] output control decode; float wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      active_instr_q  <= IR_ID_READ;
      outputs_hiz_q   <= 1'b0;
      drive_preload_q <= 1'b0;
    end else begin
      active_instr_q  <= ir_c2_q;
      outputs_hiz_q   <= ir_c2_q == IR_EXT_TEST || ir_c2_q == IR_SAMPLE_HIZ;
      drive_preload_q <= 1'b0;
    end
  end

  // preload latch; a full fifo drops the word (drain never stalls)
  always_ff @(posedge core_clk) begin
    if (srst) begin
      preload_q       <= '0;
      preload_valid_q <= 1'b0;
    end else begin
      preload_valid_q <= f_out_valid;
      if (f_out_valid) begin
        preload_q <= f_out_data;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_update_only: assert property (@(posedge tck) disable iff (srst) // RULE16
    (st_q != ST_UPD_IR && st_q != ST_RESET && !$past(srst))
      |=> $stable(ir_q)) else $error("instruction changed outside update");
  a_reset_loads_id: assert property (@(posedge tck) disable iff (srst) // RULE14
    tms [*5] |=> st_q == ST_RESET ##1 ir_q == IR_ID_READ)
    else $error("five high edges did not reset");
  a_capture_low_bits: assert property (@(posedge tck) disable iff (srst) // RULE13
    st_q == ST_CAP_IR |=> ir_shift_q[1:0] == IR_CAPTURE_LSB)
    else $error("capture did not load 01");
  a_id_present: assert property (@(posedge tck) disable iff (srst) // RULE11
    st_q == ST_CAP_DR && ir_q == IR_ID_READ |=> id_q[0] == 1'b1)
    else $error("identity bit 0 not one");
  a_id_fields: assert property (@(posedge tck) disable iff (srst) // RULE10
    st_q == ST_CAP_DR && ir_q == IR_ID_READ
      |=> id_q[ID_W-1:ID_VER_LSB] == VER_CODE &&
          id_q[ID_VER_LSB-1:ID_DEV_LSB] == DEV_CODE &&
          id_q[ID_DEV_LSB-1:ID_VEND_LSB] == VEND_CODE)
    else $error("identity fields wrong");
  a_pass_path: assert property (@(posedge tck) disable iff (srst) // RULE1
    st_q == ST_SHIFT_DR && ir_q == IR_PASS_THRU |=> pass_q == $past(tdi))
    else $error("pass-through cell not on path");
  a_chain_shift: assert property (@(posedge tck) disable iff (srst) // RULE3
    st_q == ST_SHIFT_DR && sel_chain(ir_q)
      |=> bsr_q[CHAIN_LEN-1] == $past(tdi) &&
          bsr_q[CHAIN_LEN-2:0] == $past(bsr_q[CHAIN_LEN-1:1]))
    else $error("chain not shifting");
  a_chain_capture: assert property (@(posedge tck) disable iff (srst) // RULE8
    st_q == ST_CAP_DR && sel_chain(ir_q) |=> bsr_q == $past(ring_t2_q))
    else $error("ring not captured");
  a_float_decode: assert property (@(posedge core_clk) disable iff (srst) // RULE7
    ##1 (ir_c2_q == IR_SAMPLE_HIZ || ir_c2_q == IR_EXT_TEST)
      |=> outputs_hiz_q)
    else $error("outputs not floated");
  a_no_float_pass: assert property (@(posedge core_clk) disable iff (srst) // RULE2
    ir_c2_q == IR_PASS_THRU |=> !outputs_hiz_q)
    else $error("pass-through disturbed memory");
endmodule : tap_decode
`default_nettype wire

// [core/tap_decode_pkg.sv]
// constants for the scan-port instruction decode block
`default_nettype none
package tap_decode_pkg;
  // instruction register
  localparam int unsigned IR_W          = 3;
  localparam logic [2:0]  IR_EXT_TEST   = 3'h0;
  localparam logic [2:0]  IR_ID_READ    = 3'h1;
  localparam logic [2:0]  IR_SAMPLE_HIZ = 3'h2;
  localparam logic [2:0]  IR_SAMPLE_PRE = 3'h4;
  localparam logic [2:0]  IR_PASS_THRU  = 3'h7;
  localparam logic [1:0]  IR_CAPTURE_LSB = 2'h1;
  // identification word layout
  localparam int unsigned ID_W          = 32;
  localparam int unsigned ID_VER_LSB    = 29;
  localparam int unsigned ID_DEV_LSB    = 12;
  localparam int unsigned ID_VEND_LSB   = 1;
  localparam logic        ID_PRESENT    = 1'b1;
  // arbitrary neutral identity values
  localparam logic [2:0]  ID_VER_DEF    = 3'h0;
  localparam logic [16:0] ID_DEV_DEF    = 17'h00aa5;
  localparam logic [10:0] ID_VEND_DEF   = 11'h123;
  // boundary chain and reset sequence
  localparam int unsigned BSR_LEN       = 69;
  localparam int unsigned RESET_HIGH_EDGES = 5;
  // staging fifo
  localparam int unsigned FIFO_DEPTH    = 16;
  // tap controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;
endpackage : tap_decode_pkg
`default_nettype wire

// [core/word_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`default_nettype none
module word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // honest flags straight from the count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : word_fifo
`default_nettype wire

// [bench/tap_host_model.sv]
// behavioural scan controller standing at the test pins
`default_nettype none
module tap_host_model (
  // test link driven toward the device
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  // serial answer from the device
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // clock stands low between frames, pulled-up lines idle high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // ----------------------------------------
  // single link cycle, 48 ns
  // ----------------------------------------
  // change away from rise, sample at rise
  task automatic bit_step(input logic m, input logic d, output logic o,
                          output logic oe);
    tms = m;
    tdi = d;
    #24;
    tck = 1'b1;
    o   = tdo;
    oe  = tdo_oe;
    #24;
    tck = 1'b0;
  endtask : bit_step

  // navigation step with the data line released
  task automatic step(input logic m);
    logic o;
    logic oe;
    bit_step(m, 1'b1, o, oe);
  endtask : step

  task automatic reset_seq();
    repeat (5) step(1'b1);
  endtask : reset_seq

  // code is whatever the scenario commands, ends in exit1-ir
  task automatic ir_shift(input logic [2:0] code, output logic [2:0] cap);
    logic oe;
    step(1'b1);
    step(1'b1);
    step(1'b0);
    step(1'b0);
    for (int k = 0; k < 3; k++) begin
      bit_step(k == 2, code[k], cap[k], oe);
    end
  endtask : ir_shift

  // scan len+1 bits: a one first, then the pattern; idle afterwards
  task automatic dr_scan(input int len, input logic [68:0] pat,
                         output logic [69:0] got, output logic oe_all);
    logic oe;
    got    = '0;
    oe_all = 1'b1;
    step(1'b1);
    step(1'b0);
    step(1'b0);
    for (int k = 0; k <= len; k++) begin
      bit_step(k == len, (k == 0) ? 1'b1 : pat[k-1], got[k], oe);
      oe_all = oe_all & oe;
    end
    step(1'b1);
    step(1'b0);
  endtask : dr_scan
endmodule : tap_host_model
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the scan-port instruction decode block
`default_nettype none
module tb;
  import tap_decode_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [2:0] code;
    logic       hiz;
    logic [6:0] len;
  } row_t;

  localparam logic [68:0] RING = {5'h15, 64'h0123_4567_89ab_cdef};
  localparam logic [68:0] PAT  = ~RING;
  localparam logic [31:0] ID_WORD =
    {ID_VER_DEF, ID_DEV_DEF, ID_VEND_DEF, ID_PRESENT};

  logic        core_clk, srst, tck, tms, tdi, tdo, tdo_oe;
  logic        outputs_hiz_q, drive_preload_q, preload_valid_q;
  logic [68:0] ring_in, preload_q;
  logic [2:0]  active_instr_q, cap;
  logic [69:0] got, exp;
  logic        oe;
  int          fails, samples_checked, pulses, tdo_bad, p0;
  row_t        rows [8] = '{
    '{3'h0, 1'b1, 7'd69}, '{3'h1, 1'b0, 7'd32}, '{3'h2, 1'b1, 7'd69},
    '{3'h3, 1'b0, 7'd1},  '{3'h4, 1'b0, 7'd69}, '{3'h5, 1'b0, 7'd1},
    '{3'h6, 1'b0, 7'd1},  '{3'h7, 1'b0, 7'd1}};

  // ----------------------------------------
  // design and far-side model
  // ----------------------------------------
  tap_decode u_tap_decode (
    .core_clk(core_clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in),
    .outputs_hiz_q(outputs_hiz_q), .drive_preload_q(drive_preload_q),
    .preload_q(preload_q), .active_instr_q(active_instr_q),
    .preload_valid_q(preload_valid_q));
  tap_host_model u_tap_host_model (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  // core clock and monitors
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (preload_valid_q === 1'b1) pulses++;
  // serial out moving while the link clock is high is a fault
  always @(tdo) if (tck === 1'b1 && srst === 1'b0) tdo_bad++;

  // ----------------------------------------
  // compare and verdict
  // ----------------------------------------
  task automatic check(input logic [69:0] seen, input logic [69:0] want);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // watchdog, about sixteen times the expected run
  initial begin
    #400000;
    fails++;
    results();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    srst     = 1'b1;
    ring_in  = RING;
    // reset must see link-clock edges as well as core edges
    fork
      u_tap_host_model.reset_seq();
      repeat (6) @(posedge core_clk);
    join
    @(posedge core_clk);
    #1 srst = 1'b0;
    repeat (2) @(posedge core_clk);
    check(70'(active_instr_q), 70'(IR_ID_READ));
    check(70'({outputs_hiz_q, tdo_oe}), 70'(0));
    u_tap_host_model.step(1'b0);
    // table: load each code, check side effects, then one data scan
    foreach (rows[i]) begin
      // ring pattern alternates per row, yet the chain rows 0, 2 and 4 all capture RING
      ring_in = i[0] ? PAT : RING;
      u_tap_host_model.ir_shift(rows[i].code, cap);
      check(70'(cap[1:0]), 70'(IR_CAPTURE_LSB));
      u_tap_host_model.step(1'b1);
      u_tap_host_model.step(1'b0);
      repeat (8) @(posedge core_clk);
      check(70'(outputs_hiz_q), 70'(rows[i].hiz));
      check(70'(drive_preload_q), 70'(0));
      // reserved codes act as pass-through; their register value is open
      if (!(rows[i].code inside {3'h3, 3'h5, 3'h6}))
        check(70'(active_instr_q), 70'(rows[i].code));
      p0 = pulses;
      u_tap_host_model.dr_scan(int'(rows[i].len), PAT, got, oe);
      exp = (70'(1) << rows[i].len) | ((rows[i].len == 7'd69) ? 70'(ring_in) :
            (rows[i].len == 7'd32) ? 70'(ID_WORD) : 70'(0));
      check(got, exp);
      check(70'(oe), 70'(1));
      repeat (8) @(posedge core_clk);
      check(70'(pulses - p0), 70'(rows[i].len == 7'd69));
      if (rows[i].len == 7'd69)
        check(70'(preload_q), 70'(PAT));
    end
    // held in pause-ir, the new code must not act yet
    u_tap_host_model.ir_shift(IR_SAMPLE_HIZ, cap);
    u_tap_host_model.step(1'b0);
    repeat (8) @(posedge core_clk);
    check(70'({active_instr_q, outputs_hiz_q}), 70'({IR_PASS_THRU, 1'b0}));
    u_tap_host_model.step(1'b1);
    u_tap_host_model.step(1'b1);
    u_tap_host_model.step(1'b0);
    repeat (8) @(posedge core_clk);
    check(70'({active_instr_q, outputs_hiz_q}), 70'({IR_SAMPLE_HIZ, 1'b1}));
    // abort a data shift midway with five mode-high rises
    u_tap_host_model.step(1'b1);
    u_tap_host_model.step(1'b0);
    u_tap_host_model.step(1'b0);
    u_tap_host_model.step(1'b0);
    u_tap_host_model.reset_seq();
    u_tap_host_model.step(1'b0);
    repeat (8) @(posedge core_clk);
    check(70'({active_instr_q, outputs_hiz_q}), 70'({IR_ID_READ, 1'b0}));
    u_tap_host_model.dr_scan(32, PAT, got, oe);
    check(got, (70'(1) << 32) | 70'(ID_WORD));
    check(70'(tdo_bad), 70'(0));
    results();
  end
endmodule : tb
`default_nettype wire
